// ==== rtl/irq_enable_pkg.sv ====
package irq_enable_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int STRB_W = 4;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFF_EN_WORD2 = 12'h000;
  localparam logic [11:0] OFF_EN_WORD3 = 12'h004;
  localparam logic [11:0] OFF_EN_WORD4 = 12'h008;
  localparam logic [11:0] OFF_REQ_WORD2 = 12'h00c;
  localparam logic [11:0] OFF_REQ_WORD3 = 12'h010;
  localparam logic [11:0] OFF_REQ_WORD4 = 12'h014;

  // ==========================================================
  // Implemented bit masks and reset values
  localparam logic [15:0] MASK_WORD2 = 16'hdfff;
  localparam logic [15:0] MASK_WORD3 = 16'h39ff;
  localparam logic [15:0] MASK_WORD4 = 16'h00f6;
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ==========================================================
  // Named bit positions
  // Word 2
  localparam int POS_TIMER6 = 15;
  localparam int POS_DMA_CH4 = 14;
  localparam int POS_COMPARE_CH8 = 12;
  localparam int POS_COMPARE_CH7 = 11;
  localparam int POS_COMPARE_CH6 = 10;
  localparam int POS_COMPARE_CH5 = 9;
  localparam int POS_CAPTURE_CH6 = 8;
  localparam int POS_CAPTURE_CH5 = 7;
  localparam int POS_CAPTURE_CH4 = 6;
  localparam int POS_CAPTURE_CH3 = 5;
  localparam int POS_DMA_CH3 = 4;
  localparam int POS_CAN_A_EVENT = 3;
  localparam int POS_CAN_A_RX = 2;
  localparam int POS_SPI_B_EVENT = 1;
  localparam int POS_SPI_B_ERROR = 0;
  // Word 3
  localparam int POS_DMA_CH5 = 13;
  localparam int POS_CODEC_EVENT = 12;
  localparam int POS_CODEC_ERROR = 11;
  localparam int POS_CAN_B_EVENT = 8;
  localparam int POS_CAN_B_RX = 7;
  localparam int POS_EXT_INT4 = 6;
  localparam int POS_EXT_INT3 = 5;
  localparam int POS_TIMER9 = 4;
  localparam int POS_TIMER8 = 3;
  localparam int POS_I2C_B_MASTER = 2;
  localparam int POS_I2C_B_SLAVE = 1;
  localparam int POS_TIMER7 = 0;
  // Word 4
  localparam int POS_CAN_B_TX = 7;
  localparam int POS_CAN_A_TX = 6;
  localparam int POS_DMA_CH7 = 5;
  localparam int POS_DMA_CH6 = 4;
  localparam int POS_UART_B_ERROR = 2;
  localparam int POS_UART_A_ERROR = 1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [15:0] word4;
    logic [15:0] word3;
    logic [15:0] word2;
  } irq_words_s;

  // Byte-lane merge of a write into a 16-bit word
  function automatic logic [15:0] mergeLanes(input logic [15:0] oldVal,
                                             input logic [15:0] newVal,
                                             input logic [1:0] strb);
    logic [15:0] res;
    res = oldVal;
    if (strb[0]) begin
      res[7:0] = newVal[7:0];
    end
    if (strb[1]) begin
      res[15:8] = newVal[15:8];
    end
    return res;
  endfunction : mergeLanes

endpackage : irq_enable_pkg

// ==== rtl/enable_word.sv ====
`timescale 1ns/1ns
module enable_word #(
  parameter logic [15:0] IMPL_MASK = 16'hffff
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  input wire logic [1:0] wrStrb,
  input wire logic [15:0] flags,
  output logic [15:0] enable_r,
  output logic [15:0] gated_r
);

  // ==========================================================
  // Enable storage
  // Reset masks all sources; unimplemented bits stay zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_r <= irq_enable_pkg::EN_RESET;
    end else if (wrEn) begin
      enable_r <= irq_enable_pkg::mergeLanes(enable_r, wrData, wrStrb) & IMPL_MASK;
    end
  end

  // ==========================================================
  // Request gating
  // Pass flagged sources only while enabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gated_r <= irq_enable_pkg::EN_RESET;
    end else begin
      gated_r <= flags & enable_r & IMPL_MASK;
    end
  end

endmodule : enable_word

// ==== rtl/apb_reg_port.sv ====
`timescale 1ns/1ns
module apb_reg_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic addrHit,
  input wire logic [31:0] rdData,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wrCommit
);

  logic setup;

  // Setup phase detect
  assign setup = psel & ~penable;

  // ==========================================================
  // Zero-wait answer, registered in the setup cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= irq_enable_pkg::RDATA_ZERO;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addrHit; // Unmapped address
      prdata <= (setup & ~pwrite & addrHit) ? rdData : irq_enable_pkg::RDATA_ZERO;
    end
  end

  // Write lands on the access edge that sees pready
  assign wrCommit = psel & penable & pready & pwrite & ~pslverr;

endmodule : apb_reg_port

// ==== rtl/irq_enable_bank.sv ====
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module irq_enable_bank (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire irq_enable_pkg::irq_words_s srcFlags,
  output irq_enable_pkg::irq_words_s gatedReq,
  output logic anyReq_r
);

  // ==========================================================
  // Address decode
  logic selEn2;
  logic selEn3;
  logic selEn4;
  logic selReq2;
  logic selReq3;
  logic selReq4;
  logic addrHit;
  logic wrCommit;
  logic [31:0] rdData;
  irq_enable_pkg::irq_words_s enables;

  // Word-aligned register selects
  assign selEn2 = (paddr == irq_enable_pkg::OFF_EN_WORD2);
  assign selEn3 = (paddr == irq_enable_pkg::OFF_EN_WORD3);
  assign selEn4 = (paddr == irq_enable_pkg::OFF_EN_WORD4);
  assign selReq2 = (paddr == irq_enable_pkg::OFF_REQ_WORD2);
  assign selReq3 = (paddr == irq_enable_pkg::OFF_REQ_WORD3);
  assign selReq4 = (paddr == irq_enable_pkg::OFF_REQ_WORD4);
  assign addrHit = selEn2 | selEn3 | selEn4 | selReq2 | selReq3 | selReq4;

  // ==========================================================
  // Read data mux; upper half always zero
  always_comb begin
    rdData = irq_enable_pkg::RDATA_ZERO;
    if (selEn2) begin
      rdData[15:0] = enables.word2;
    end else if (selEn3) begin
      rdData[15:0] = enables.word3;
    end else if (selEn4) begin
      rdData[15:0] = enables.word4;
    end else if (selReq2) begin
      rdData[15:0] = gatedReq.word2;
    end else if (selReq3) begin
      rdData[15:0] = gatedReq.word3;
    end else if (selReq4) begin
      rdData[15:0] = gatedReq.word4;
    end
  end

  // ==========================================================
  // APB handshake
  apb_reg_port u_port (
    .clk(clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .addrHit(addrHit),
    .rdData(rdData),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wrCommit(wrCommit)
  );

  // ==========================================================
  // Enable words; masks place capture ch4/ch3, DMA ch3, CAN rx, SPI bits
  enable_word #(.IMPL_MASK(irq_enable_pkg::MASK_WORD2)) u_word2 (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrCommit & selEn2),
    .wrData(pwdata[15:0]),
    .wrStrb(pstrb[1:0]),
    .flags(srcFlags.word2),
    .enable_r(enables.word2),
    .gated_r(gatedReq.word2)
  );

  enable_word #(.IMPL_MASK(irq_enable_pkg::MASK_WORD3)) u_word3 (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrCommit & selEn3),
    .wrData(pwdata[15:0]),
    .wrStrb(pstrb[1:0]),
    .flags(srcFlags.word3),
    .enable_r(enables.word3),
    .gated_r(gatedReq.word3)
  );

  // Word 4 mask keeps DMA ch7/ch6 at bits 5/4, upper byte, bit 3 and bit 0 empty
  enable_word #(.IMPL_MASK(irq_enable_pkg::MASK_WORD4)) u_word4 (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrCommit & selEn4),
    .wrData(pwdata[15:0]),
    .wrStrb(pstrb[1:0]),
    .flags(srcFlags.word4),
    .enable_r(enables.word4),
    .gated_r(gatedReq.word4)
  );

  // ==========================================================
  // Summary request toward the arbiter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      anyReq_r <= 1'b0;
    end else begin
      anyReq_r <= |(srcFlags & enables);
    end
  end

endmodule : irq_enable_bank

// ==== dv/irq_enable_bank_properties.sv ====
`timescale 1ns/1ns
module irq_enable_bank_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire irq_enable_pkg::irq_words_s srcFlags,
  input wire irq_enable_pkg::irq_words_s gatedReq,
  input wire logic anyReq_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Bus answers
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error outside access");
  a_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  a_upper_half_zero: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read half set");
  a_word4_empty_zero: assert property (pready && !pwrite && paddr == 12'h008
    |-> prdata[15:8] == 8'h0 && !prdata[3] && !prdata[0])
    else $error("word 4 empty bit set");
  // ==========================================
  // Request gating
  a_gate_mask: assert property ((gatedReq & ~{irq_enable_pkg::MASK_WORD4,
    irq_enable_pkg::MASK_WORD3, irq_enable_pkg::MASK_WORD2}) == 48'h0)
    else $error("unimplemented request set");
  a_flag_needed: assert property ((gatedReq & ~$past(srcFlags)) == 48'h0)
    else $error("request without flag");
  a_any_tracks: assert property (anyReq_r == (|gatedReq))
    else $error("summary request mismatch");
  c_write: cover property (pready && pwrite);
  c_error: cover property (pready && pslverr);
  c_request: cover property (anyReq_r);
endmodule : irq_enable_bank_checker

bind irq_enable_bank irq_enable_bank_checker chk (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .srcFlags(srcFlags), .gatedReq(gatedReq),
  .anyReq_r(anyReq_r));

// ==== dv/test_irq_enable_bank.sv ====
`timescale 1ns/1ns
module test_irq_enable_bank;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, anyReq_r, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  irq_enable_pkg::irq_words_s srcFlags, gatedReq;
  int mismatches, cmpCount;
  logic [15:0] masks [3] = '{irq_enable_pkg::MASK_WORD2, irq_enable_pkg::MASK_WORD3,
    irq_enable_pkg::MASK_WORD4};
  int wIdx [8] = '{0, 0, 0, 0, 0, 0, 2, 2};
  int bitPos [8] = '{6, 5, 4, 2, 1, 0, 5, 4};

  irq_enable_bank dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .srcFlags(srcFlags), .gatedReq(gatedReq),
    .anyReq_r(anyReq_r));

  // ==========================================
  // Report and compare
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // ==========================================
  // Bus transfers
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
                     input logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
    apb(1'b0, a, 16'h0, 4'h0);
    check({16'h0, rd}, {16'h0, exp});
    check({47'h0, err}, {47'h0, expErr});
  endtask : rdChk

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    srcFlags = '1;
    mismatches = 0;
    cmpCount = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(gatedReq, 48'h0);
    for (int i = 0; i < 3; i++) begin
      rdChk(12'(4 * i), 32'h0, 1'b0);
      apb(1'b1, 12'(4 * i), 16'hffff, 4'hf);
      rdChk(12'(4 * i), {16'h0, masks[i]}, 1'b0);
      apb(1'b1, 12'(4 * i), 16'h0, 4'hf);
    end
    apb(1'b1, 12'h000, 16'hffff, 4'h1);
    rdChk(12'h000, 32'h0000_00ff, 1'b0);
    apb(1'b1, 12'h000, 16'h0, 4'hf);
    apb(1'b1, 12'h018, 16'hffff, 4'hf);
    check({47'h0, err}, 48'h1);
    rdChk(12'h018, 32'h0, 1'b1);
    // Eight chosen enables alone (six in word 2, two in word 4), all flags raised
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'(4 * wIdx[i]), 16'h1 << bitPos[i], 4'hf);
      @(posedge clk);
      check(gatedReq, 48'h1 << (16 * wIdx[i] + bitPos[i]));
      check({47'h0, anyReq_r}, 48'h1);
      rdChk(12'(12 + 4 * wIdx[i]), 32'h1 << bitPos[i], 1'b0);
      // Enabled but no pending flag: nothing passes
      srcFlags <= '0;
      repeat (2) @(posedge clk);
      check(gatedReq, 48'h0);
      check({47'h0, anyReq_r}, 48'h0);
      srcFlags <= '1;
      apb(1'b1, 12'(4 * wIdx[i]), 16'h0, 4'hf);
      @(posedge clk);
      check(gatedReq, 48'h0);
      check({47'h0, anyReq_r}, 48'h0);
    end
    // Mid-run reset clears a set enable
    apb(1'b1, 12'h000, 16'hffff, 4'hf);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(gatedReq, 48'h0);
    rdChk(12'h000, 32'h0, 1'b0);
    results();
  end
endmodule : test_irq_enable_bank
